// [cim_pkg.sv]
// Constants, types and field layout of the charger interrupt status and mask.
// How it works
// - Status B bits 7..0 hold voltage-limit, contact-detect-timeout, current-limit, thermal-shutdown, supply-valid, zone, high and extreme flags.
// - The contact-detect-timeout flag is set when the contact detect wait times out.
// - The high-temperature flag is set on entering the band above 45 C and below 60 C.
// - Mask A bits 7..0 are charger-type, overvoltage, system-battery-voltage, reserved, battery-detect, charge-status, thermal-regulation, charge-timeout.
// - The charger-type mask bit gates the charger-type-change flag of status A.
// - A mask bit of 0 blocks its source and a 1 lets it pass.
// - The system-battery-voltage mask bit gates its change flag of status A.
// - The thermal-regulation mask bit gates the thermal-regulation-change flag.
// - The charge-timeout mask bit gates the charge-timeout-change flag.
// - The charger-type-change flag is set whenever the four-bit charger type changes.
// - A status bit shows thermal shutdown as 1, and its changes raise the thermal-shutdown flag.
package cim_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [2:0] CIM_IDX_STATUS_D = 3'h4;
    localparam logic [2:0] CIM_IDX_FLAGS_A = 3'h5;
    localparam logic [2:0] CIM_IDX_FLAGS_B = 3'h6;
    localparam logic [2:0] CIM_IDX_MASK_A = 3'h7;

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int CIM_B_VLIM = 7;
    localparam int CIM_B_DCD = 6;
    localparam int CIM_B_ILIM = 5;
    localparam int CIM_B_TSD = 4;
    localparam int CIM_B_SUPPLY = 3;
    localparam int CIM_B_ZONE = 2;
    localparam int CIM_B_HIGHT = 1;
    localparam int CIM_B_EXTT = 0;
    localparam int CIM_A_TYPE = 7;
    localparam int CIM_A_OV = 6;
    localparam int CIM_A_SYSBV = 5;
    localparam int CIM_A_RSV = 4;
    localparam int CIM_A_BATDET = 3;
    localparam int CIM_A_CHGSTAT = 2;
    localparam int CIM_A_TREG = 1;
    localparam int CIM_A_TMO = 0;

    // ----------------------------------------------------------------
    // Reset values and write masks.
    // ----------------------------------------------------------------
    localparam logic [7:0] CIM_FLAGS_RST = 8'h00;
    localparam logic [7:0] CIM_MASK_A_RST = 8'h00;
    localparam logic [7:0] CIM_MASK_A_WMASK = 8'hEF;
    localparam logic [7:0] CIM_ALL_ONES = 8'hFF;
    localparam logic [23:0] CIM_RD_PAD = 24'h00_0000;

    // ----------------------------------------------------------------
    // Battery temperature thresholds in degrees Celsius.
    // ----------------------------------------------------------------
    localparam logic signed [7:0] CIM_T_HIGH_LO_C = 8'sh2D;
    localparam logic signed [7:0] CIM_T_HIGH_HI_C = 8'sh3C;
    localparam logic signed [7:0] CIM_T_COLD_C = 8'sh00;

    // ----------------------------------------------------------------
    // Types.
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CIM_BUS_IDLE = 2'b01,
        CIM_BUS_ACK = 2'b10
    } cim_bus_e;

    typedef struct packed {
        logic [3:0] charger_type;
        logic overvoltage;
        logic sys_batt_v;
        logic batt_detect;
        logic [2:0] charge_status;
        logic thermal_reg;
        logic charge_timeout;
    } cim_first_src_s;

    typedef struct packed {
        logic voltage_limit;
        logic current_limit;
        logic data_contact_detect_timeout;
        logic thermal_shutdown_state;
        logic supply_valid;
        logic [2:0] temp_zone;
        logic signed [7:0] batt_temp_c;
    } cim_second_src_s;

endpackage : cim_pkg

// [cim_charger_interrupt_status_mask.sv]
// Interrupt status banks, first mask register and Wishbone slave.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module cim_charger_interrupt_status_mask
    import cim_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [4:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire cim_first_src_s src_a,
    input wire cim_second_src_s src_b,
    output logic first_bank_irq
);

    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    cim_bus_e state;
    cim_first_src_s prev_a;
    cim_second_src_s prev_b;
    logic primed;
    logic prev_high;
    logic prev_ext;
    logic high_band;
    logic ext_band;
    logic req;
    logic rd_req;
    logic wr_mask;
    logic [2:0] idx;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] mask_a;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] gated_a;
    logic [7:0] status_d;
    logic [31:0] next_rdata;

    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    assign idx = wb_adr[4:2];
    assign req = wb_cyc && wb_stb && (state == CIM_BUS_IDLE);
    assign rd_req = req && !wb_we;
    assign wr_mask = req && wb_we && (idx == CIM_IDX_MASK_A) && wb_sel[0];

    // ----------------------------------------------------------------
    // Temperature bands.
    // ----------------------------------------------------------------
    assign high_band = (src_b.batt_temp_c > CIM_T_HIGH_LO_C) &&
                       (src_b.batt_temp_c < CIM_T_HIGH_HI_C);
    assign ext_band = (src_b.batt_temp_c < CIM_T_COLD_C) ||
                      (src_b.batt_temp_c > CIM_T_HIGH_HI_C);

    // ----------------------------------------------------------------
    // Previous input values for change and edge detection.
    // ----------------------------------------------------------------
    // The first cycle after reset only samples the inputs, so that a
    // nonzero level present at reset does not look like a change.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            primed <= 1'b0;
            prev_a <= '0;
            prev_b <= '0;
            prev_high <= 1'b0;
            prev_ext <= 1'b0;
        end else begin
            primed <= 1'b1;
            prev_a <= src_a;
            prev_b <= src_b;
            prev_high <= high_band;
            prev_ext <= ext_band;
        end
    end

    // ----------------------------------------------------------------
    // Event detection.
    // ----------------------------------------------------------------
    always_comb begin
        set_a = '0;
        set_b = '0;
        if (primed) begin
            set_a[CIM_A_TYPE] = src_a.charger_type !=
                                prev_a.charger_type;
            set_a[CIM_A_OV] = src_a.overvoltage != prev_a.overvoltage;
            set_a[CIM_A_SYSBV] = src_a.sys_batt_v != prev_a.sys_batt_v;
            set_a[CIM_A_BATDET] = src_a.batt_detect != prev_a.batt_detect;
            set_a[CIM_A_CHGSTAT] = src_a.charge_status !=
                                   prev_a.charge_status;
            set_a[CIM_A_TREG] = src_a.thermal_reg != prev_a.thermal_reg;
            set_a[CIM_A_TMO] = src_a.charge_timeout !=
                               prev_a.charge_timeout;
            set_b[CIM_B_VLIM] = src_b.voltage_limit &&
                                !prev_b.voltage_limit;
            set_b[CIM_B_DCD] = src_b.data_contact_detect_timeout &&
                               !prev_b.data_contact_detect_timeout;
            set_b[CIM_B_ILIM] = src_b.current_limit &&
                                !prev_b.current_limit;
            set_b[CIM_B_TSD] = src_b.thermal_shutdown_state !=
                               prev_b.thermal_shutdown_state;
            set_b[CIM_B_SUPPLY] = src_b.supply_valid != prev_b.supply_valid;
            set_b[CIM_B_ZONE] = src_b.temp_zone != prev_b.temp_zone;
            set_b[CIM_B_HIGHT] = high_band && !prev_high;
            set_b[CIM_B_EXTT] = ext_band && !prev_ext;
        end
    end

    // Reading a bank clears it at the edge that also captures read data.
    assign clr_a = (rd_req && idx == CIM_IDX_FLAGS_A) ? CIM_ALL_ONES : '0;
    assign clr_b = (rd_req && idx == CIM_IDX_FLAGS_B) ?
                   CIM_ALL_ONES : '0;

    // ----------------------------------------------------------------
    // Sticky flags, one flip-flop per bit; a set beats a clear.
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (!rstn) begin
                flags_a[i] <= CIM_FLAGS_RST[i];
                flags_b[i] <= CIM_FLAGS_RST[i];
            end else begin
                flags_a[i] <= set_a[i] || (flags_a[i] && !clr_a[i]);
                flags_b[i] <= set_b[i] || (flags_b[i] && !clr_b[i]);
            end
        end
    end

    // ----------------------------------------------------------------
    // First mask register.
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mask_a <= CIM_MASK_A_RST;
        end else if (wr_mask) begin
            mask_a <= wb_dat_w[7:0] & CIM_MASK_A_WMASK;
        end
    end

    // ----------------------------------------------------------------
    // Masked first-bank interrupt.
    // ----------------------------------------------------------------
    // The output lags the flags by one cycle so it comes from a flop.
    assign gated_a = flags_a & mask_a;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            first_bank_irq <= 1'b0;
        end else begin
            first_bank_irq <= |gated_a;
        end
    end

    // ----------------------------------------------------------------
    // Read data.
    // ----------------------------------------------------------------
    assign status_d = {4'h0, src_b.thermal_shutdown_state, src_a.thermal_reg,
                       src_b.data_contact_detect_timeout,
                       src_a.charge_timeout};

    always_comb begin
        next_rdata = '0;
        case (idx)
            CIM_IDX_STATUS_D: begin
                next_rdata = {CIM_RD_PAD, status_d};
            end
            CIM_IDX_FLAGS_A: begin
                next_rdata = {CIM_RD_PAD, flags_a};
            end
            CIM_IDX_FLAGS_B: begin
                next_rdata = {CIM_RD_PAD, flags_b};
            end
            CIM_IDX_MASK_A: begin
                next_rdata = {CIM_RD_PAD, mask_a};
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Wishbone handshake.
    // ----------------------------------------------------------------
    // Unmapped addresses are acknowledged and read as zero, so a stray
    // access never hangs the bus.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= CIM_BUS_IDLE;
            wb_ack <= 1'b0;
            wb_dat_r <= '0;
        end else begin
            case (state)
                CIM_BUS_IDLE: begin
                    if (req) begin
                        state <= CIM_BUS_ACK;
                        wb_ack <= 1'b1;
                        wb_dat_r <= wb_we ? '0 : next_rdata;
                    end
                end
                CIM_BUS_ACK: begin
                    state <= CIM_BUS_IDLE;
                    wb_ack <= 1'b0;
                end
                default: begin
                    state <= CIM_BUS_IDLE;
                    wb_ack <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_VLIM_SET: assert property (
        set_b[CIM_B_VLIM] |=> flags_b[CIM_B_VLIM])
        else $error("voltage limit flag not set");

    AST_DCD_SET: assert property (
        primed && src_b.data_contact_detect_timeout &&
        !prev_b.data_contact_detect_timeout |=> flags_b[CIM_B_DCD])
        else $error("contact detect timeout flag not set");

    AST_HIGH_SET: assert property (
        primed && $rose(high_band) |=> flags_b[CIM_B_HIGHT])
        else $error("high temperature flag not set");

    AST_EXT_SET: assert property (
        primed && src_b.batt_temp_c > CIM_T_HIGH_HI_C && !prev_ext
        |=> flags_b[CIM_B_EXTT])
        else $error("extreme temperature flag not set");

    AST_TYPE_CHG: assert property (
        primed && src_a.charger_type != prev_a.charger_type
        |=> flags_a[CIM_A_TYPE])
        else $error("charger type change flag not set");

    AST_TSD_CHG: assert property (
        primed && $changed(src_b.thermal_shutdown_state)
        |=> flags_b[CIM_B_TSD])
        else $error("thermal shutdown flag not set");

    AST_RC_CLEAR: assert property (
        rd_req && idx == CIM_IDX_FLAGS_B && set_b == '0
        |=> flags_b == '0 ##1 !wb_ack)
        else $error("status B not cleared by read");

    AST_SET_WINS: assert property (
        clr_b != '0 && set_b != '0
        |=> (flags_b & $past(set_b)) == $past(set_b))
        else $error("event lost during clear");

    AST_RD_B_DATA: assert property (
        rd_req && idx == CIM_IDX_FLAGS_B
        |=> wb_ack && wb_dat_r[7:0] == $past(flags_b))
        else $error("status B read data wrong");

    AST_MASK_GATE: assert property (
        1'b1 |=> first_bank_irq == |$past(gated_a))
        else $error("interrupt output not gated by mask");

    AST_TYPE_MASKED: assert property (
        flags_a == 8'h80 && !mask_a[CIM_A_TYPE] |=> !first_bank_irq)
        else $error("masked charger type event passed");

    AST_MASK_RSV: assert property (
        wr_mask |=> mask_a == ($past(wb_dat_w[7:0]) & CIM_MASK_A_WMASK)
        && !mask_a[CIM_A_RSV])
        else $error("mask write wrong");

    AST_ACK_PULSE: assert property (
        req |=> wb_ack ##1 !wb_ack)
        else $error("ack not a one-cycle answer");

    AST_ILIM_SET: assert property (
        primed && src_b.current_limit && !prev_b.current_limit
        |=> flags_b[CIM_B_ILIM])
        else $error("current limit flag not set");

    AST_LIMIT_HELD: assert property (
        src_b.voltage_limit && prev_b.voltage_limit &&
        clr_b[CIM_B_VLIM] |=> !flags_b[CIM_B_VLIM])
        else $error("held voltage limit set its flag again");

    AST_SUPPLY_CHG: assert property (
        primed && src_b.supply_valid != prev_b.supply_valid
        |=> flags_b[CIM_B_SUPPLY])
        else $error("supply valid flag not set");

    AST_ZONE_CHG: assert property (
        primed && src_b.temp_zone != prev_b.temp_zone
        |=> flags_b[CIM_B_ZONE])
        else $error("temperature zone flag not set");

    AST_COLD_SET: assert property (
        primed && src_b.batt_temp_c < CIM_T_COLD_C && !prev_ext
        |=> flags_b[CIM_B_EXTT])
        else $error("cold extreme flag not set");

    AST_RSV_ZERO: assert property (
        !flags_a[CIM_A_RSV] && !mask_a[CIM_A_RSV])
        else $error("reserved bit of bank A set");

    AST_OV_PASS: assert property (
        flags_a[CIM_A_OV] && mask_a[CIM_A_OV] |=> first_bank_irq)
        else $error("unmasked overvoltage event blocked");

    AST_SYSBV_MASKED: assert property (
        flags_a == (8'h01 << CIM_A_SYSBV) && !mask_a[CIM_A_SYSBV]
        |=> !first_bank_irq)
        else $error("masked system battery voltage event passed");

    AST_TREG_MASKED: assert property (
        flags_a == (8'h01 << CIM_A_TREG) && !mask_a[CIM_A_TREG]
        |=> !first_bank_irq)
        else $error("masked thermal regulation event passed");

    AST_TMO_MASKED: assert property (
        flags_a == (8'h01 << CIM_A_TMO) && !mask_a[CIM_A_TMO]
        |=> !first_bank_irq)
        else $error("masked charge timeout event passed");

    AST_RC_CLEAR_A: assert property (
        rd_req && idx == CIM_IDX_FLAGS_A && set_a == '0
        |=> flags_a == '0)
        else $error("status A not cleared by read");

    AST_RD_PAD: assert property (
        wb_ack |-> wb_dat_r[31:8] == CIM_RD_PAD)
        else $error("upper read data bits not zero");

    AST_ACK_ON_REQ: assert property (
        !wb_cyc |=> !wb_ack)
        else $error("ack without a request");

    COV_READ_B: cover property (
        rd_req && idx == CIM_IDX_FLAGS_B && flags_b != '0);
    COV_SET_CLR: cover property (clr_b != '0 && set_b != '0);
    COV_IRQ: cover property ($rose(first_bank_irq));
    COV_MASK_WR: cover property (wr_mask ##2 rd_req);
    COV_COLD: cover property (
        primed && !prev_ext && src_b.batt_temp_c < CIM_T_COLD_C);

endmodule : cim_charger_interrupt_status_mask

// [tb_charger_interrupt_status_mask.sv]
// Self-checking testbench for the charger interrupt status and mask block.
`timescale 1ns/1ps
module tb_charger_interrupt_status_mask;
    import cim_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design instance.
    // ----------------------------------------------------------------
    logic core_clk;
    logic rstn;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [4:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    cim_first_src_s src_a;
    cim_second_src_s src_b;
    logic first_bank_irq;
    int n_mismatch;
    int n_tests;
    int idx;

    cim_charger_interrupt_status_mask i_dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack),
        .src_a(src_a),
        .src_b(src_b),
        .first_bank_irq(first_bank_irq)
    );

    // ----------------------------------------------------------------
    // Clock and bench tasks.
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    // The request stands until ack is sampled high at a rising edge.
    task automatic wb(input logic we, input logic [4:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge core_clk);
        chk("wb_ack_idle", 32'h0000_0000, {31'h0, wb_ack});
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat_w <= {24'h00_0000, d};
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [4:0] a, input logic [7:0] e,
                      input string nm);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(nm, {24'h00_0000, e}, q);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic irq_chk(input logic e, input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
        chk("first_bank_irq", {31'h0, e}, {31'h0, first_bank_irq});
        @(posedge core_clk);
    endtask : irq_chk

    task automatic toggle_a(input int i);
        case (i)
            7: src_a.charger_type <= src_a.charger_type + 4'h1;
            6: src_a.overvoltage <= ~src_a.overvoltage;
            5: src_a.sys_batt_v <= ~src_a.sys_batt_v;
            3: src_a.batt_detect <= ~src_a.batt_detect;
            2: src_a.charge_status <= src_a.charge_status + 3'h1;
            1: src_a.thermal_reg <= ~src_a.thermal_reg;
            default: src_a.charge_timeout <= ~src_a.charge_timeout;
        endcase
    endtask : toggle_a

    task automatic event_b(input int i);
        case (i)
            7: src_b.voltage_limit <= 1'b1;
            6: src_b.data_contact_detect_timeout <= 1'b1;
            5: src_b.current_limit <= 1'b1;
            4: src_b.thermal_shutdown_state <= 1'b1;
            3: src_b.supply_valid <= ~src_b.supply_valid;
            2: src_b.temp_zone <= 3'h2;
            1: src_b.batt_temp_c <= 8'sh32;
            default: src_b.batt_temp_c <= 8'sh46;
        endcase
        repeat (4) @(posedge core_clk);
        rd(5'h18, 8'h01 << i, "event_flags_second");
    endtask : event_b

    // ----------------------------------------------------------------
    // Test sequence.
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rstn = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 5'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0000_0000;
        src_a = '0;
        src_b = '0;
        src_b.batt_temp_c = 8'sh19;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(5'h1C, 8'h00, "mask_reset");
        rd(5'h18, 8'h00, "flags_b_reset");
        wr(5'h00, 8'hFF);
        rd(5'h00, 8'h00, "unmapped");
        wr(5'h1C, 8'hFF);
        rd(5'h1C, 8'hEF, "mask_layout");
        wr(5'h1C, 8'h00);
        // Band edges 45 and 60 are outside both temperature bands.
        src_b.batt_temp_c <= 8'sh2D;
        repeat (4) @(posedge core_clk);
        rd(5'h18, 8'h00, "temp_45");
        src_b.batt_temp_c <= 8'sh3C;
        repeat (4) @(posedge core_clk);
        rd(5'h18, 8'h00, "temp_60");
        for (idx = 7; idx >= 0; idx--) begin
            event_b(idx);
        end
        rd(5'h18, 8'h00, "flags_b_cleared");
        // Leave the hot band first, so that the cold band is a fresh entry.
        src_b.batt_temp_c <= 8'sh19;
        repeat (4) @(posedge core_clk);
        src_b.batt_temp_c <= 8'shFB;
        repeat (4) @(posedge core_clk);
        rd(5'h18, 8'h01, "temp_cold");
        irq_chk(1'b0, 1);
        rd(5'h10, 8'h0A, "status_d");
        // A source that is masked still flags but raises no interrupt.
        toggle_a(7);
        irq_chk(1'b0, 4);
        rd(5'h14, 8'h80, "flags_a_masked");
        for (idx = 7; idx >= 0; idx--) begin
            if (idx != 4) begin
                wr(5'h1C, 8'h01 << idx);
                toggle_a(idx);
                irq_chk(1'b1, 4);
                rd(5'h14, 8'h01 << idx, "flags_a");
                irq_chk(1'b0, 2);
                toggle_a((idx + 1) % 8 == 4 ? 5 : (idx + 1) % 8);
                irq_chk(1'b0, 4);
                rd(5'h14, 8'h01 << ((idx + 1) % 8 == 4 ? 5 : (idx + 1) % 8),
                   "flags_a_other");
            end
        end
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

endmodule : tb_charger_interrupt_status_mask
